// [tef_pkg.sv]
package tef_pkg;

  localparam int CNT_W = 16;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;

  // Channel mode field, ignored while center-aligned mode is on
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [1:0] MODE_EPWM    = 2'h2;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } tef_dir_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       edge_level_sel_hi;
    logic       edge_level_sel_lo;
  } tef_chan_cfg_s;

  // Set beats clear; an event also voids a pending read
  function automatic logic tef_next_flag(input logic flag,
                                         input logic armed,
                                         input logic evt,
                                         input logic wr0);
    tef_next_flag = evt | (flag & ~(wr0 & armed));
  endfunction : tef_next_flag

  function automatic logic tef_next_armed(input logic flag,
                                          input logic armed,
                                          input logic evt,
                                          input logic rd,
                                          input logic wr0);
    tef_next_armed = ~evt & ((rd & flag) | (armed & ~wr0));
  endfunction : tef_next_armed

endpackage : tef_pkg

// [tef_chan.sv]
`timescale 1ns/100ps

module tef_chan
  import tef_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Configuration
  input  wire tef_chan_cfg_s    cfg,
  input  wire logic             center_aligned_select,
  input  wire logic [CNT_W-1:0] value,
  // Counter view
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic             tick,
  // Pin and software access
  input  wire logic             pin,
  input  wire logic             rd,
  input  wire logic             wr0,
  // Result
  output      logic             channel_event_flag
);

  logic pin_prev;
  logic armed;

  wire logic cap_mode  = ~center_aligned_select & (cfg.mode == MODE_CAPTURE);
  wire logic rise      = pin & ~pin_prev;
  wire logic fall      = ~pin & pin_prev;
  wire logic sel_hi    = cfg.edge_level_sel_hi;
  wire logic sel_lo    = cfg.edge_level_sel_lo;
  wire logic cap_evt   = cap_mode & ((~sel_hi & sel_lo & rise) |
                                     (sel_hi & ~sel_lo & fall) |
                                     (sel_hi & sel_lo & (rise | fall)));
  // Compare, edge PWM and both center PWM matches share one strobe
  wire logic match_evt = ~cap_mode & tick & (cnt == value);
  wire logic evt       = cap_evt | match_evt;
  wire logic next_flag  = tef_next_flag(channel_event_flag, armed, evt,
                                        wr0);
  wire logic next_armed = tef_next_armed(channel_event_flag, armed, evt,
                                         rd, wr0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_prev           <= 1'b0;
      armed              <= 1'b0;
      channel_event_flag <= 1'b0;
    end else begin
      pin_prev           <= pin;
      armed              <= next_armed;
      channel_event_flag <= next_flag;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chan_match_set_a: assert property (
    (tick && !cap_mode && cnt == value) |=> channel_event_flag)
    else $error("counter match did not set channel flag");

  capture_off_a: assert property (
    (cap_mode && !sel_hi && !sel_lo) |-> !evt)
    else $error("disabled capture produced an event");

  rise_capture_a: assert property (
    (cap_mode && !sel_hi && sel_lo && pin && !pin_prev) |=>
    channel_event_flag)
    else $error("rising edge capture did not set flag");

  fall_ignored_a: assert property (
    (cap_mode && !sel_hi && sel_lo && !pin && pin_prev) |-> !cap_evt)
    else $error("falling edge captured in rising-only mode");

  chan_clear_a: assert property (
    (channel_event_flag && rd && !evt) ##1 (wr0 && !rd && !evt) |=>
    !channel_event_flag)
    else $error("read then zero write did not clear channel flag");

endmodule : tef_chan

// [tef_top.sv]
`timescale 1ns/100ps

module tef_top
  import tef_pkg::*;
#(
  parameter int N_CHAN = 2
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Counter control
  input  wire logic                         count_en,
  input  wire logic [CNT_W-1:0]             modulo,
  input  wire logic                         center_aligned_select,
  input  wire logic                         overflow_irq_enable,
  input  wire logic                         ovf_rd,
  input  wire logic                         ovf_wr0,
  // Channels
  input  wire tef_chan_cfg_s [N_CHAN-1:0]   chan_cfg,
  input  wire logic [N_CHAN-1:0][CNT_W-1:0] chan_value,
  input  wire logic [N_CHAN-1:0]            chan_in,
  input  wire logic [N_CHAN-1:0]            channel_irq_enable,
  input  wire logic [N_CHAN-1:0]            chan_rd,
  input  wire logic [N_CHAN-1:0]            chan_wr0,
  // Status and request
  output      logic [CNT_W-1:0]             count,
  output      tef_dir_e                     count_dir,
  output      logic                         overflow_flag,
  output      logic [N_CHAN-1:0]            channel_event_flag,
  output      logic                         irq
);

  logic tick;
  logic ovf_armed;

  // Modulo zero means a free-running counter
  wire logic [CNT_W-1:0] top = (modulo == CNT_ZERO) ? CNT_MAX : modulo;
  wire logic at_top  = (count == top);
  wire logic at_mod  = (count == modulo);
  wire logic at_zero = (count == CNT_ZERO);
  wire logic going_up = (count_dir == DIR_UP);

  wire logic turn_down = center_aligned_select & going_up & at_mod;
  wire logic turn_up   = center_aligned_select & ~going_up & at_zero;
  wire logic step_down = center_aligned_select &
                         ((~going_up & ~at_zero) | turn_down);

  wire logic [CNT_W-1:0] up_next = (!center_aligned_select && at_top) ?
                                   CNT_ZERO : count + CNT_ONE;
  wire logic [CNT_W-1:0] cnt_step = step_down ? count - CNT_ONE : up_next;
  wire logic [CNT_W-1:0] next_count = count_en ? cnt_step : count;

  wire tef_dir_e next_dir = !center_aligned_select ? DIR_UP :
                            !count_en              ? count_dir :
                            turn_down              ? DIR_DOWN :
                            turn_up                ? DIR_UP :
                                                     count_dir;

  wire logic ovf_evt = count_en & (center_aligned_select ? turn_down :
                                   at_top);
  wire logic next_ovf_flag  = tef_next_flag(overflow_flag, ovf_armed,
                                            ovf_evt, ovf_wr0);
  wire logic next_ovf_armed = tef_next_armed(overflow_flag, ovf_armed,
                                             ovf_evt, ovf_rd,
                                             ovf_wr0);
  // Registered, so the request trails its flag or enable by one clock
  wire logic next_irq = (overflow_flag & overflow_irq_enable) |
                        (|(channel_event_flag & channel_irq_enable));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count         <= CNT_ZERO;
      count_dir     <= DIR_UP;
      tick          <= 1'b0;
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
      irq           <= 1'b0;
    end else begin
      count         <= next_count;
      count_dir     <= next_dir;
      tick          <= count_en;
      overflow_flag <= next_ovf_flag;
      ovf_armed     <= next_ovf_armed;
      irq           <= next_irq;
    end
  end

  // Channels match against the counter after it has moved
  for (genvar i = 0; i < N_CHAN; i++) begin : g_chan
    tef_chan u_chan (
      .clk                   (clk),
      .rst_b                 (rst_b),
      .cfg                   (chan_cfg[i]),
      .center_aligned_select (center_aligned_select),
      .value                 (chan_value[i]),
      .cnt                   (count),
      .tick                  (tick),
      .pin                   (chan_in[i]),
      .rd                    (chan_rd[i]),
      .wr0                   (chan_wr0[i]),
      .channel_event_flag    (channel_event_flag[i])
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  up_wrap_a: assert property (
    (count_en && !center_aligned_select && count == top) |=>
    (count == CNT_ZERO && overflow_flag))
    else $error("wrap at terminal count missed");

  up_step_a: assert property (
    (count_en && !center_aligned_select && count != top) |=>
    (count == $past(count) + CNT_ONE && count_dir == DIR_UP))
    else $error("up counter did not step by one");

  center_turn_a: assert property (
    (count_en && center_aligned_select && count_dir == DIR_UP &&
     count == modulo && modulo != CNT_ZERO && $stable(modulo)) |=>
    (count_dir == DIR_DOWN && overflow_flag))
    else $error("turn at modulo did not set overflow");

  down_step_a: assert property (
    (count_en && center_aligned_select && count_dir == DIR_DOWN &&
     count != CNT_ZERO) |=> (count == $past(count) - CNT_ONE))
    else $error("down counter did not step by one");

  no_center_ovf_a: assert property (
    (count_en && center_aligned_select && count_dir == DIR_DOWN &&
     !overflow_flag && !ovf_wr0) |=> !overflow_flag)
    else $error("overflow set while counting down");

  irq_level_a: assert property (
    (overflow_flag && overflow_irq_enable) |=> irq)
    else $error("enabled overflow flag gave no request");

  irq_quiet_a: assert property (
    (!(overflow_flag && overflow_irq_enable) &&
     !(|(channel_event_flag & channel_irq_enable))) |=> !irq)
    else $error("request without enabled flag");

  clear_seq_a: assert property (
    (overflow_flag && ovf_rd && !ovf_evt) ##1
    (ovf_wr0 && !ovf_rd && !ovf_evt) |=> !overflow_flag)
    else $error("read then zero write did not clear overflow");

  no_read_keep_a: assert property (
    (overflow_flag && ovf_wr0 && !ovf_armed) |=> overflow_flag)
    else $error("zero write without read cleared overflow");

  restart_a: assert property (
    (overflow_flag && ovf_rd && !ovf_evt) ##1 ovf_evt ##1
    (ovf_wr0 && !ovf_rd) |=> overflow_flag)
    else $error("event between read and write was lost");

  set_wins_a: assert property (
    (ovf_evt && ovf_wr0) |=> overflow_flag)
    else $error("clear beat a same-cycle event");

  chan_irq_a: assert property (
    (|(channel_event_flag & channel_irq_enable)) |=> irq)
    else $error("enabled channel flag gave no request");

  // A flag may only rise on its own event, never from a stray write
  ovf_rise_a: assert property (
    (!overflow_flag && !ovf_evt) |=> !overflow_flag)
    else $error("overflow flag rose without an event");

  ovf_hold_a: assert property (
    (overflow_flag && !ovf_wr0) |=> overflow_flag)
    else $error("overflow flag dropped without a zero write");

  wr_disarm_a: assert property (
    (ovf_wr0 && !ovf_rd) |=> !ovf_armed)
    else $error("zero write left the read armed");

  disarm_a: assert property (
    ovf_evt |=> !ovf_armed)
    else $error("event left a pending read armed");

  free_wrap_a: assert property (
    (count_en && !center_aligned_select && modulo == CNT_ZERO &&
     count == CNT_MAX) |=> (count == CNT_ZERO && overflow_flag))
    else $error("free running wrap missed");

  center_up_a: assert property (
    (count_en && center_aligned_select && count_dir == DIR_DOWN &&
     count == CNT_ZERO) |=> (count == CNT_ONE && count_dir == DIR_UP))
    else $error("down counter did not turn up at zero");

  dir_up_a: assert property (
    !center_aligned_select |=> count_dir == DIR_UP)
    else $error("direction left up without center mode");

  count_hold_a: assert property (
    !count_en |=> count == $past(count))
    else $error("counter moved without its enable");

  chan_cov_c: cover property ($rose(channel_event_flag[0]));
  wrap_cov_c: cover property (
    count_en && !center_aligned_select && at_top && modulo != CNT_ZERO);
  center_cov_c: cover property (turn_down ##[1:1000] turn_up);
  clear_cov_c: cover property (
    overflow_flag && ovf_rd ##1 ovf_wr0 ##1 !overflow_flag);
  irq_cov_c: cover property ($rose(irq));

endmodule : tef_top

// [tef_intc_model.sv]
`timescale 1ns/100ps

module tef_intc_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Request from the timer
  input  wire logic irq,
  // Request as the sink sees it
  output      logic seen
);
  // Level sensitive: no edge memory, so a held request is never lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) seen <= 1'b0;
    else seen <= irq;
  end
endmodule : tef_intc_model

// [tef_tb_top.sv]
`timescale 1ns/100ps

`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("BAD %0t: got %0h want %0h", $time, (a), (e)); \
  end \
end

module tef_tb_top
  import tef_pkg::*;
;
  localparam int NC = 2;
  // Center walk, modulo 2: count, dir, overflow and channel 0 per step
  localparam logic [CNT_W-1:0] C_CNT [5] = '{16'h0001, 16'h0002,
    16'h0001, 16'h0000, 16'h0001};
  localparam logic [4:0] C_DIR = 5'h0C;
  localparam logic [4:0] C_OVF = 5'h04;
  localparam logic [4:0] C_CH0 = 5'h15;

  logic                     clk = 1'b0;
  logic                     rst_b, count_en, ovf_rd, ovf_wr0;
  logic                     center_aligned_select, overflow_irq_enable;
  logic [CNT_W-1:0]         modulo, count;
  tef_chan_cfg_s [NC-1:0]   chan_cfg;
  logic [NC-1:0][CNT_W-1:0] chan_value;
  logic [NC-1:0]            chan_in, channel_irq_enable, chan_rd, chan_wr0;
  logic [NC-1:0]            channel_event_flag;
  tef_dir_e                 count_dir;
  logic                     overflow_flag, irq, seen;
  int                       fails = 0;
  int                       n_compared = 0;

  always #25 clk = ~clk;

  tef_top #(.N_CHAN(NC)) DUT (
    .clk(clk), .rst_b(rst_b), .count_en(count_en), .modulo(modulo),
    .center_aligned_select(center_aligned_select),
    .overflow_irq_enable(overflow_irq_enable),
    .ovf_rd(ovf_rd), .ovf_wr0(ovf_wr0), .chan_cfg(chan_cfg),
    .chan_value(chan_value), .chan_in(chan_in),
    .channel_irq_enable(channel_irq_enable),
    .chan_rd(chan_rd), .chan_wr0(chan_wr0), .count(count),
    .count_dir(count_dir), .overflow_flag(overflow_flag),
    .channel_event_flag(channel_event_flag), .irq(irq));

  tef_intc_model sink (.clk(clk), .rst_b(rst_b), .irq(irq), .seen(seen));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Index NC is the overflow flag; wr low reads, wr high writes zero
  // An idle cycle follows, so back-to-back calls never retoggle a strobe
  task automatic access(input int idx, input logic wr);
    if (idx == NC) {ovf_wr0, ovf_rd} = {wr, ~wr};
    else {chan_wr0[idx], chan_rd[idx]} = {wr, ~wr};
    cyc(1);
    {ovf_wr0, ovf_rd, chan_wr0, chan_rd} = '0;
    cyc(1);
  endtask : access

  task automatic clr(input int idx);
    access(idx, 1'b0);
    access(idx, 1'b1);
  endtask : clr

  // One counter step plus an idle cycle so registered results settle
  task automatic tick(input int n);
    repeat (n) begin
      count_en = 1'b1;
      cyc(1);
      count_en = 1'b0;
      cyc(1);
    end
  endtask : tick

  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial begin
    cyc(90000);
    fails++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    {count_en, ovf_rd, ovf_wr0, center_aligned_select} = 4'h0;
    overflow_irq_enable = 1'b1;
    modulo = 16'h0003;
    chan_cfg = '0;
    chan_value = '0;
    {chan_in, channel_irq_enable, chan_rd, chan_wr0} = 8'h10;
    cyc(20);
    rst_b = 1'b1;
    `CHK({count, overflow_flag, channel_event_flag, irq}, 20'h0)
    tick(3);
    `CHK({count, overflow_flag}, {16'h0003, 1'b0})
    tick(1);
    `CHK({count, overflow_flag, irq}, {CNT_ZERO, 2'h3})
    cyc(1);
    `CHK(seen, 1'b1)
    access(NC, 1'b1);
    `CHK(overflow_flag, 1'b1)
    access(NC, 1'b0);
    tick(4);
    access(NC, 1'b1);
    `CHK(overflow_flag, 1'b1)
    access(NC, 1'b0);
    tick(3);
    {count_en, ovf_wr0} = 2'h3;
    cyc(1);
    {count_en, ovf_wr0} = 2'h0;
    `CHK(overflow_flag, 1'b1)
    overflow_irq_enable = 1'b0;
    cyc(2);
    `CHK(irq, 1'b0)
    overflow_irq_enable = 1'b1;
    clr(NC);
    `CHK(overflow_flag, 1'b0)
    modulo = CNT_ZERO;
    count_en = 1'b1;
    cyc(65535);
    `CHK({count, overflow_flag}, {CNT_MAX, 1'b0})
    cyc(1);
    count_en = 1'b0;
    `CHK({count, overflow_flag}, {CNT_ZERO, 1'b1})
    clr(NC);
    for (int s = 0; s < 4; s++) begin
      chan_cfg[0].edge_level_sel_hi = s[1];
      chan_cfg[0].edge_level_sel_lo = s[0];
      chan_in[0] = 1'b1;
      cyc(1);
      `CHK(channel_event_flag[0], s[0])
      clr(0);
      chan_in[0] = 1'b0;
      cyc(1);
      `CHK(channel_event_flag[0], s[1])
      cyc(1);
      `CHK(irq, s[1])
      clr(0);
    end
    // Mid-run reset gives a known count for the match walks
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    modulo = 16'h0005;
    chan_cfg[0].mode = MODE_EPWM;
    chan_value[0] = 16'h0003;
    chan_cfg[1].mode = MODE_COMPARE;
    chan_value[1] = 16'h0002;
    for (int i = 1; i <= 3; i++) begin
      tick(1);
      `CHK(channel_event_flag, {i >= 2, i == 3})
    end
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    center_aligned_select = 1'b1;
    modulo = 16'h0002;
    chan_value[0] = 16'h0001;
    for (int i = 0; i < 5; i++) begin
      tick(1);
      `CHK(count, C_CNT[i])
      `CHK(count_dir, tef_dir_e'(C_DIR[i]))
      `CHK(overflow_flag, C_OVF[i])
      `CHK(channel_event_flag[0], C_CH0[i])
      clr(0);
      clr(NC);
    end
    report_and_stop();
  end
endmodule : tef_tb_top
